// >>> core/rxsfm_defs.vh
// Purpose: constants for the receiver serial port and frame manager
// Assumes: 40 MHz core clock
// Notes: definitions only
`ifndef RXSFM_DEFS_VH
`define RXSFM_DEFS_VH
`define RXSFM_BYTE_BITS 4'h8
`define RXSFM_CNT_ZERO 4'h0
`define RXSFM_HALF_W 16
`define RXSFM_HALF_MIN 16'h0004
`define RXSFM_HALF_DEF 16'h03E8
`define RXSFM_ON_DEF 24'h00_9C40
`define RXSFM_PRE_BITS 4'h6
`define RXSFM_PIN_IDLE 5'h18
`define RXSFM_ONE_CNT 16'h0001
`define RXSFM_ID2 2'b00
`define RXSFM_ID4 2'b01
`define RXSFM_ID5 2'b10
`define RXSFM_HD1 2'b00
`define RXSFM_HD2 2'b01
`define RXSFM_HD4 2'b10
`endif

// >>> core/rxsfm_top.v
// Purpose: serial port and data manager of a short-range radio receiver
// Assumes: link clock and all pins sampled by two flops on clock_i
// Notes: register storage lives outside; command bytes are reported as pulses
// Functional notes
// RULE1: low select means host master, high device master
// RULE2: disable floats port pins, state kept
// RULE3: eight clocks per byte, MSB first
// RULE4: idle device master holds clock, data low
// RULE5: slave read data valid on falling edge
// RULE6: host starts each transfer with command byte
// RULE7: first byte after select fall is command
// RULE8: command holds count, address, direction bit
// RULE9: manager off forwards raw Manchester stream
// RULE10: parse preamble, identifier, header, body, end
// RULE11: identifier length 2, 4, 5, 6 bits
// RULE12: complemented identifier also matches
// RULE13: header length 1, 2, 4, 6 bits
// RULE14: complemented header matches, inverts output
// RULE15: two equal halves end the message
// RULE16: forward only after identifier then header
// RULE17: start on Manchester at selected rate
// RULE18: strobed mode stays awake on identifier only
// RULE19: after header shift every bit until end
// RULE20: data stable at falling recovered clock
// RULE21: on period counted in crystal clocks
// RULE22: failures restart preamble search and recovery
`timescale 1ns/1ps
`include "rxsfm_defs.vh"
module rxsfm_top #(
	parameter [23:0] ON_CYCLES = `RXSFM_ON_DEF
) (
	// Clock and reset
	input wire clock_i,
	input wire rst_i,
	// Serial port pins
	input wire config_select_n_i,
	input wire serial_enable_n_i,
	input wire sclk_i,
	output reg sclk_o,
	output reg sclk_oe_o,
	input wire mosi_i,
	output reg mosi_o,
	output reg mosi_oe_o,
	output reg miso_o,
	output reg miso_oe_o,
	// Configuration
	input wire manager_en_i,
	input wire strobe_en_i,
	input wire [1:0] id_length_sel_i,
	input wire [5:0] id_value_i,
	input wire [1:0] header_length_sel_i,
	input wire [5:0] header_value_i,
	input wire [15:0] half_bit_cycles_i,
	// Demodulator and strobe oscillator
	input wire demod_i,
	input wire strobe_wake_i,
	// Register access side
	output reg cmd_valid_o,
	output reg [1:0] reg_count_o,
	output reg [4:0] first_reg_addr_o,
	output reg cmd_read_o,
	output reg wr_valid_o,
	output reg [7:0] wr_data_o,
	input wire [7:0] rd_data_i,
	output reg rd_take_o,
	// Status
	output reg run_o,
	output reg frame_active_o,
	output reg invert_o
);
	localparam S_SEARCH = 3'h0;
	localparam S_ID = 3'h1;
	localparam S_HDR = 3'h2;
	localparam S_MSG = 3'h3;
	// Select and enable idle high; resetting their syncs low would fake a select fall
	localparam [4:0] PIN_IDLE = `RXSFM_PIN_IDLE;
	// Two-flop synchronisers, one per pin, generated
	wire [4:0] pin_raw = {config_select_n_i, serial_enable_n_i, sclk_i, mosi_i, demod_i};
	reg [4:0] sync1_reg;
	reg [4:0] sync2_reg;
	genvar gi;
	generate
		for (gi = 0; gi < 5; gi = gi + 1) begin : g_sync
			always @(posedge clock_i) begin
				sync1_reg[gi] <= rst_i ? PIN_IDLE[gi] : pin_raw[gi];
				sync2_reg[gi] <= rst_i ? PIN_IDLE[gi] : sync1_reg[gi];
			end
		end
	endgenerate
	wire cfg_n = sync2_reg[4];
	wire se_n = sync2_reg[3];
	wire sck = sync2_reg[2];
	wire mosi_s = sync2_reg[1];
	wire dem = sync2_reg[0];
	reg cfg_d_reg;
	reg sck_d_reg;
	reg wake_s1_reg;
	reg wake_s2_reg;
	wire cfg_fall = cfg_d_reg & ~cfg_n;
	wire sck_rise = ~sck_d_reg & sck;
	wire sck_fall = sck_d_reg & ~sck;
	// Configuration-mode slave
	reg [2:0] bitc_reg;
	reg [7:0] shin_reg;
	reg [7:0] shout_reg;
	reg first_reg;
	reg rd_mode_reg;
	wire [7:0] byte_in = {shin_reg[6:0], mosi_s};
	always @(posedge clock_i) begin
		if (rst_i) begin
			cfg_d_reg <= 1'b1;
			sck_d_reg <= 1'b0;
			wake_s1_reg <= 1'b0;
			wake_s2_reg <= 1'b0;
			bitc_reg <= 3'h0;
			shin_reg <= 8'h00;
			shout_reg <= 8'h00;
			first_reg <= 1'b0;
			rd_mode_reg <= 1'b0;
			cmd_valid_o <= 1'b0;
			reg_count_o <= 2'h0;
			first_reg_addr_o <= 5'h00;
			cmd_read_o <= 1'b0;
			wr_valid_o <= 1'b0;
			wr_data_o <= 8'h00;
			rd_take_o <= 1'b0;
			miso_o <= 1'b0;
		end else begin
			cfg_d_reg <= cfg_n;
			sck_d_reg <= sck;
			wake_s1_reg <= strobe_wake_i;
			wake_s2_reg <= wake_s1_reg;
			cmd_valid_o <= 1'b0;
			wr_valid_o <= 1'b0;
			rd_take_o <= 1'b0;
			if (cfg_fall) begin
				bitc_reg <= 3'h0; // RULE7
				first_reg <= 1'b1;
				rd_mode_reg <= 1'b0;
			end else if (~cfg_n && ~se_n) begin
				if (sck_rise) begin
					shin_reg <= byte_in; // RULE3
					bitc_reg <= bitc_reg + 3'h1;
					if (bitc_reg == 3'h7) begin
						if (first_reg) begin
							cmd_valid_o <= 1'b1; // RULE6
							reg_count_o <= byte_in[7:6]; // RULE8
							first_reg_addr_o <= byte_in[5:1];
							cmd_read_o <= byte_in[0];
							rd_mode_reg <= byte_in[0];
							first_reg <= 1'b0;
						end else if (!rd_mode_reg) begin
							wr_valid_o <= 1'b1;
							wr_data_o <= byte_in;
						end
					end
				end
				if (sck_fall) begin
					// Load read byte at byte boundary, then shift MSB first
					if (bitc_reg == 3'h0 && rd_mode_reg) begin
						miso_o <= rd_data_i[7]; // RULE5
						shout_reg <= {rd_data_i[6:0], 1'b0};
						rd_take_o <= 1'b1;
					end else begin
						miso_o <= shout_reg[7];
						shout_reg <= {shout_reg[6:0], 1'b0};
					end
				end
			end
		end
	end
	// Manchester recovery: measure half-bit runs of the demodulated level
	reg [2:0] st_reg;
	reg [15:0] run_reg;
	reg dem_d_reg;
	reg [3:0] pre_reg;
	reg phase_reg;
	reg h1_reg;
	reg [2:0] cnt_reg;
	reg [5:0] sh_reg;
	reg [23:0] on_reg;
	reg skip_reg;
	reg bit_stb;
	reg bit_val;
	reg viol;
	wire [15:0] hb = (half_bit_cycles_i < `RXSFM_HALF_MIN) ? `RXSFM_HALF_MIN : half_bit_cycles_i;
	wire edge_d = dem ^ dem_d_reg;
	wire [15:0] hb_half = {1'b0, hb[15:1]};
	wire [15:0] hb_3q = hb + hb_half;
	wire [2:0] id_len = (id_length_sel_i == `RXSFM_ID2) ? 3'd2 : (id_length_sel_i == `RXSFM_ID4) ? 3'd4 :
		(id_length_sel_i == `RXSFM_ID5) ? 3'd5 : 3'd6; // RULE11
	wire [2:0] hd_len = (header_length_sel_i == `RXSFM_HD1) ? 3'd1 : (header_length_sel_i == `RXSFM_HD2) ? 3'd2 :
		(header_length_sel_i == `RXSFM_HD4) ? 3'd4 : 3'd6; // RULE13
	wire [5:0] sh_nx = {sh_reg[4:0], bit_val};
	wire [5:0] id_mask = ~(6'h3F << id_len);
	wire [5:0] hd_mask = ~(6'h3F << hd_len);
	wire id_hit = ((sh_nx & id_mask) == (id_value_i & id_mask)); // RULE12
	wire id_inv = ((sh_nx & id_mask) == (~id_value_i & id_mask));
	wire hd_hit = ((sh_nx & hd_mask) == (header_value_i & hd_mask));
	wire hd_inv = ((sh_nx & hd_mask) == (~header_value_i & hd_mask));
	// Sampling midway through the second half; the first half decides the bit
	always @* begin
		bit_stb = 1'b0;
		bit_val = ~dem;
		viol = 1'b0;
		if (st_reg != S_SEARCH && run_reg == hb_half && phase_reg) begin
			bit_stb = ~(dem == h1_reg);
			bit_val = h1_reg;
			viol = (dem == h1_reg); // RULE15
		end
	end
	wire dm_active = manager_en_i & (~strobe_en_i | run_o | wake_s2_reg); // RULE17
	always @(posedge clock_i) begin
		if (rst_i) begin
			st_reg <= S_SEARCH;
			run_reg <= 16'h0000;
			dem_d_reg <= 1'b0;
			pre_reg <= 4'h0;
			phase_reg <= 1'b0;
			h1_reg <= 1'b0;
			cnt_reg <= 3'h0;
			sh_reg <= 6'h00;
			on_reg <= 24'h00_0000;
			skip_reg <= 1'b0;
			run_o <= 1'b0;
			frame_active_o <= 1'b0;
			invert_o <= 1'b0;
		end else begin
			dem_d_reg <= dem;
			run_reg <= edge_d ? 16'h0000 : run_reg + `RXSFM_ONE_CNT;
			// Strobe on window in crystal clocks; off time belongs to strobe oscillator
			if (!strobe_en_i)
				run_o <= 1'b1;
			else if (wake_s2_reg && !run_o) begin
				run_o <= 1'b1;
				on_reg <= ON_CYCLES; // RULE21
			end else if (run_o && st_reg == S_SEARCH || run_o && st_reg == S_ID) begin
				if (on_reg == 24'h00_0000)
					run_o <= 1'b0; // RULE18
				else
					on_reg <= on_reg - 24'h00_0001;
			end
			if (!dm_active) begin
				st_reg <= S_SEARCH;
				pre_reg <= 4'h0;
				frame_active_o <= 1'b0;
			end else if (st_reg == S_SEARCH) begin
				// Preamble: runs of one half-bit, lock phase on a full-bit run
				if (edge_d) begin
					// Count saturates so a longer preamble still locks
					if (run_reg >= hb_half && run_reg < hb_3q) begin
						if (pre_reg != `RXSFM_PRE_BITS)
							pre_reg <= pre_reg + 4'h1;
					end else if (run_reg >= hb_3q && pre_reg == `RXSFM_PRE_BITS) begin
						st_reg <= S_ID; // RULE10
						phase_reg <= 1'b1;
						skip_reg <= 1'b1;
						h1_reg <= dem_d_reg;
						sh_reg <= 6'h00;
						cnt_reg <= 3'h0;
					end else
						pre_reg <= 4'h0;
				end
			end else begin
				// Resync on every edge; toggle phase each half-bit
				if (edge_d || run_reg == hb) begin
					phase_reg <= ~phase_reg;
					// Leaving the second half: the new level is the first half of the next cell
					if (phase_reg)
						h1_reg <= dem;
				end
				if (viol || run_reg > hb_3q + hb) begin
					st_reg <= S_SEARCH; // RULE22
					pre_reg <= 4'h0;
					frame_active_o <= 1'b0;
				end else if (bit_stb && skip_reg) begin
					// The locking cell closes the preamble and is not an identifier bit
					skip_reg <= 1'b0;
				end else if (bit_stb) begin
					sh_reg <= sh_nx;
					cnt_reg <= (cnt_reg == 3'h7) ? cnt_reg : cnt_reg + 3'h1;
					if (st_reg == S_ID && cnt_reg + 3'h1 == id_len) begin
						if (id_hit || id_inv) begin
							st_reg <= S_HDR;
							cnt_reg <= 3'h0;
							on_reg <= ON_CYCLES;
						end else begin
							st_reg <= S_SEARCH; // RULE22
							pre_reg <= 4'h0;
						end
					end else if (st_reg == S_HDR && cnt_reg + 3'h1 == hd_len) begin
						if (hd_hit || hd_inv) begin
							st_reg <= S_MSG; // RULE16
							invert_o <= hd_inv & ~hd_hit; // RULE14
							frame_active_o <= 1'b1;
						end else begin
							st_reg <= S_SEARCH;
							pre_reg <= 4'h0;
						end
					end
				end
			end
		end
	end
	// Device-master output: bit set with clock low, clock rises mid-bit, falls a quarter bit later
	reg msg_bit_reg;
	reg sck_phase_reg;
	reg [15:0] sck_cnt_reg;
	always @(posedge clock_i) begin
		if (rst_i) begin
			sclk_o <= 1'b0;
			sclk_oe_o <= 1'b0;
			mosi_o <= 1'b0;
			mosi_oe_o <= 1'b0;
			miso_oe_o <= 1'b0;
			msg_bit_reg <= 1'b0;
			sck_phase_reg <= 1'b0;
			sck_cnt_reg <= 16'h0000;
		end else begin
			sclk_oe_o <= ~se_n & cfg_n; // RULE1
			mosi_oe_o <= ~se_n & cfg_n; // RULE2
			miso_oe_o <= ~se_n & ~cfg_n & rd_mode_reg;
			if (!cfg_n || !manager_en_i) begin
				sclk_o <= 1'b0; // RULE4
				mosi_o <= manager_en_i ? 1'b0 : dem; // RULE9
				sck_phase_reg <= 1'b0;
			end else if (st_reg == S_MSG && bit_stb) begin
				mosi_o <= bit_val ^ invert_o; // RULE19
				sclk_o <= 1'b0;
				sck_phase_reg <= 1'b1;
				sck_cnt_reg <= 16'h0000;
			end else if (sck_phase_reg) begin
				sck_cnt_reg <= sck_cnt_reg + `RXSFM_ONE_CNT;
				if (sck_cnt_reg == hb) begin
					sclk_o <= 1'b1;
				end else if (sck_cnt_reg == hb + hb_half) begin
					sclk_o <= 1'b0; // RULE20
					sck_phase_reg <= 1'b0;
				end
			end else if (st_reg != S_MSG) begin
				sclk_o <= 1'b0;
				mosi_o <= 1'b0;
			end
		end
	end
endmodule // rxsfm_top

// >>> tb/rxsfm_sva.sv
// Purpose: port-level checks of rxsfm_top
// Assumes: pins reach the logic through two sync flops
// Notes: bound below to every instance
`timescale 1ns/1ps
module rxsfm_sva (
	// Clock and reset
	input wire clock_i,
	input wire rst_i,
	// Pins
	input wire config_select_n_i,
	input wire serial_enable_n_i,
	input wire sclk_i,
	input wire sclk_o,
	input wire sclk_oe_o,
	input wire mosi_o,
	input wire mosi_oe_o,
	input wire miso_o,
	input wire miso_oe_o,
	// Mode and status
	input wire manager_en_i,
	input wire cmd_valid_o,
	input wire run_o,
	input wire frame_active_o
);
	default clocking cb @(posedge clock_i); endclocking
	default disable iff (rst_i);
	// Four clocks cover the sync flops and the output register
	property p_float; serial_enable_n_i [*4] |-> !(sclk_oe_o | mosi_oe_o | miso_oe_o); endproperty
	a_float: assert property (p_float) else $error("pin driven while disabled");
	property p_host_mode; !config_select_n_i [*4] |-> !sclk_oe_o && !mosi_oe_o; endproperty
	a_host_mode: assert property (p_host_mode) else $error("master pins driven in host mode");
	property p_slave_only; config_select_n_i [*4] |-> !miso_oe_o; endproperty
	a_slave_only: assert property (p_slave_only) else $error("slave pin driven as master");
	// Margin of eight clocks lets the last bit clock finish
	property p_idle; manager_en_i && $past(manager_en_i, 4) && sclk_oe_o && !frame_active_o
		&& !$past(frame_active_o, 8) |-> !sclk_o && !mosi_o; endproperty
	a_idle: assert property (p_idle) else $error("idle master lines not low");
	property p_cmd_cfg; cmd_valid_o |-> !$past(config_select_n_i, 3) && !$past(serial_enable_n_i, 3); endproperty
	a_cmd_cfg: assert property (p_cmd_cfg) else $error("command outside configuration");
	property p_mosi_fall; manager_en_i && $fell(sclk_o) |-> $stable(mosi_o); endproperty
	a_mosi_fall: assert property (p_mosi_fall) else $error("data moved at clock fall");
	property p_miso_fall; miso_oe_o && $fell(sclk_i) |-> $stable(miso_o); endproperty
	a_miso_fall: assert property (p_miso_fall) else $error("read data moved at clock fall");
	property p_sleep; $fell(run_o) |-> !frame_active_o && !$past(frame_active_o); endproperty
	a_sleep: assert property (p_sleep) else $error("slept during a frame");
endmodule // rxsfm_sva
bind rxsfm_top rxsfm_sva u_sva (.*);

// >>> tb/rxsfm_host.sv
// Purpose: host microcontroller as serial master in configuration mode
// Assumes: 200 ns link clock, clock still between bytes
// Notes: slave data is taken at each falling edge
`timescale 1ns/1ps
module rxsfm_host (
	// Pins driven by the host
	output logic sel_n_o,
	output logic sclk_o,
	output logic mosi_o,
	// Pin read by the host
	input wire logic miso_i
);
	// Idle: deselected, clock low
	initial begin
		sel_n_o = 1'b1;
		sclk_o = 1'b0;
		mosi_o = 1'b0;
	end
	// One byte, eight clocks, top bit first
	task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
		for (int i = 7; i >= 0; i--) begin
			mosi_o = tx[i];
			#100 sclk_o = 1'b1;
			#100 rx[i] = miso_i;
			sclk_o = 1'b0;
		end
	endtask
	// A fresh select fall before every command byte
	task automatic start();
		sel_n_o = 1'b1;
		#400 sel_n_o = 1'b0;
		#400;
	endtask
	// Hand the port back to the receiver
	task automatic stop();
		#400 sel_n_o = 1'b1;
		mosi_o = ~mosi_o; // Released line must not keep the last bit
		#400;
	endtask
endmodule // rxsfm_host

// >>> tb/tb_rx_spi_frame_manager.sv
// Purpose: self-checking bench for rxsfm_top
// Assumes: 25 ns clock, 200 ns host link clock, 8 clocks per half bit
// Notes: a short on window keeps the strobe test brief
`timescale 1ns/1ps
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin n_fail++; \
	$display("ERROR %s expected %0h seen %0h", nm, e, g); end end
module tb_rx_spi_frame_manager;
	localparam int IL[4] = '{2, 4, 5, 6};
	localparam int HL[4] = '{1, 2, 4, 6};
	logic clock_i = 0, rst_i = 1, serial_enable_n_i = 0, manager_en_i = 0, strobe_en_i = 0;
	logic demod_i = 0, strobe_wake_i = 0;
	logic [1:0] id_length_sel_i = 0, header_length_sel_i = 0;
	logic [5:0] id_value_i = 0, header_value_i = 0;
	logic [7:0] rd_data_i = 0, rx;
	wire config_select_n_i, h_sclk, h_mosi, sclk_o, sclk_oe_o, mosi_o, mosi_oe_o, miso_o, miso_oe_o;
	wire cmd_valid_o, cmd_read_o, wr_valid_o, rd_take_o, run_o, frame_active_o, invert_o;
	wire [1:0] reg_count_o;
	wire [4:0] first_reg_addr_o;
	wire [7:0] wr_data_o;
	int n_fail = 0, total_checks = 0;
	logic [7:0] cq[$], wq[$];
	logic oq[$];
	// Shared pins: whoever has its enable up drives
	wire sclk_pin = sclk_oe_o ? sclk_o : h_sclk;
	wire mosi_pin = mosi_oe_o ? mosi_o : h_mosi;
	rxsfm_top #(.ON_CYCLES(24'h00_0032)) DUT (.*, .sclk_i(sclk_pin), .mosi_i(mosi_pin), .half_bit_cycles_i(16'h0008));
	rxsfm_host u_host (.sel_n_o(config_select_n_i), .sclk_o(h_sclk), .mosi_o(h_mosi), .miso_i(miso_oe_o ? miso_o : !miso_o));
	initial forever #12.5 clock_i = ~clock_i;
	// Capture what the register side and the host receive
	always @(posedge clock_i) begin
		if (cmd_valid_o) cq.push_back({reg_count_o, first_reg_addr_o, cmd_read_o});
		if (wr_valid_o) wq.push_back(wr_data_o);
	end
	always @(negedge sclk_o) if (mosi_oe_o && manager_en_i) oq.push_back(mosi_o);
	task automatic half(input logic b); demod_i = b; repeat (8) @(negedge clock_i); endtask
	task automatic mbit(input logic b); half(b); half(!b); endtask
	// Preamble, sync bit, identifier, header, body, then two equal halves
	task automatic frame(input int il, input logic [5:0] iv, input int hl, input logic [5:0] hv, input logic [7:0] d);
		repeat (4) mbit(1'b0);
		mbit(1'b1);
		for (int i = il - 1; i >= 0; i--) mbit(iv[i]);
		for (int i = hl - 1; i >= 0; i--) mbit(hv[i]);
		for (int i = 7; i >= 0; i--) mbit(d[i]);
		half(d[0]); half(d[0]); half(1'b0);
		repeat (40) @(negedge clock_i);
	endtask
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", total_checks, n_fail);
		if (n_fail == 0 && total_checks > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	// A hang is cut short well past the expected run length
	initial begin #1_000_000; n_fail++; tally_and_finish(); end
	initial begin
		int c, d;
		c = $urandom(6132);
		repeat (15) @(negedge clock_i);
		`CHK("oe in reset", 3'b000, {sclk_oe_o, mosi_oe_o, miso_oe_o})
		@(negedge clock_i); rst_i = 0;
		repeat (4) @(negedge clock_i);
		// Commands with a write or read byte; the last is sent while disabled
		for (int k = 0; k < 8; k++) begin
			c = $urandom; d = $urandom; rd_data_i = 8'($urandom); serial_enable_n_i = (k == 7);
			u_host.start();
			u_host.xfer(c[7:0], rx);
			u_host.xfer(d[7:0], rx);
			u_host.stop();
			repeat (8) @(negedge clock_i);
			if (k == 7) `CHK("refused", 0, cq.size() + wq.size())
			else begin
				`CHK("command", c[7:0], cq.pop_front())
				if (c[0]) `CHK("read data", rd_data_i, rx)
				else `CHK("write data", d[7:0], wq.pop_front())
			end
		end
		serial_enable_n_i = 0;
		// Manager off: the raw stream shows on the data pin
		for (int k = 0; k < 6; k++) begin
			demod_i = 1'($urandom); repeat (6) @(negedge clock_i);
			`CHK("raw data", demod_i, mosi_o)
		end
		// All lengths, both complements, then a wrong identifier
		manager_en_i = 1;
		for (int k = 0; k < 5; k++) begin
			id_length_sel_i = k[1:0]; header_length_sel_i = k[1:0];
			id_value_i = 6'($urandom); header_value_i = 6'($urandom); oq.delete();
			d = (k == 4) ? 32'h0000_0055 : $urandom; // No preamble-like runs after the failed identifier
			frame(IL[k % 4], (k == 2) ? ~id_value_i : (k == 4) ? id_value_i ^ 6'h01 : id_value_i,
				HL[k % 4], (k % 2) ? ~header_value_i : header_value_i, d[7:0]);
			`CHK("bit count", (k == 4) ? 0 : 8, oq.size())
			for (int i = 0; i < oq.size(); i++) `CHK("data bit", d[7 - i] ^ (k % 2 == 1), oq[i])
		end
		// Strobed wake with no frame falls back asleep
		strobe_en_i = 1; strobe_wake_i = 1; repeat (2) @(negedge clock_i); strobe_wake_i = 0;
		repeat (25) @(negedge clock_i);
		`CHK("awake", 1'b1, run_o)
		repeat (40) @(negedge clock_i);
		`CHK("asleep", 1'b0, run_o)
		tally_and_finish();
	end
endmodule // tb_rx_spi_frame_manager
